/* File: core/rtc_value_pkg.sv */
// ==================================================
// Register map and field layout
package rtc_value_pkg;

  localparam logic [3:0]  DH_OFS_C     = 4'h0;
  localparam logic [3:0]  MS_OFS_C     = 4'h4;
  localparam logic [3:0]  UNLOCK_OFS_C = 4'h8;

  localparam int          DOW_LSB_C    = 8;
  localparam int          HRT_LSB_C    = 4;
  localparam int          HRU_LSB_C    = 0;
  localparam int          MNT_LSB_C    = 12;
  localparam int          MNU_LSB_C    = 8;
  localparam int          SCT_LSB_C    = 4;
  localparam int          SCU_LSB_C    = 0;

  localparam logic [15:0] DH_MASK_C     = 16'h073F;
  localparam logic [15:0] MS_MASK_C     = 16'h7F7F;
  localparam logic [3:0]  DOW_MAX_C     = 4'h6;
  localparam logic [3:0]  HRT_MAX_C     = 4'h2;
  localparam logic [3:0]  TEN6_MAX_C    = 4'h5;
  localparam logic [3:0]  UNIT_MAX_C    = 4'h9;
  localparam logic        UNLOCK_RST_C  = 1'b0;

  typedef struct packed {
    logic [2:0] dow;
    logic [1:0] hr_tens;
    logic [3:0] hr_units;
  } day_hours_t;

  typedef struct packed {
    logic [2:0] min_tens;
    logic [3:0] min_units;
    logic [2:0] sec_tens;
    logic [3:0] sec_units;
  } min_sec_t;

endpackage : rtc_value_pkg

/* File: core/rtc_time_value_registers.sv */
`timescale 1ns/10ps
// Operation
// [R1] Weekday digit in bits 10..8, legal 0..6.
// [R2] Hour tens digit in bits 5..4, legal 0..2.
// [R3] Hour units digit in bits 3..0, legal 0..9.
// [R4] Minute tens digit in bits 14..12, legal 0..5.
// [R5] Minute units digit in bits 11..8, legal 0..9.
// [R6] Second tens digit in bits 6..4, legal 0..5.
// [R7] Second units digit in bits 3..0, legal 0..9.
// [R8] Weekday/hours write accepted only while unlock bit is one.
// [R9] Unused bits of both value registers read as zero.
// [R10] Locked weekday/hours write ignored; digits undefined until first written.
module rtc_time_value_registers
  import rtc_value_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  output logic             UNLOCK_O
);

  // ==================================================
  // Bus decode
  logic        req;
  logic        hit_wh;
  logic        hit_ms;
  logic        hit_ul;
  logic        lo_en;
  logic        hi_en;
  logic        wr_wh;
  logic        wr_ms;
  logic        wr_ul;

  assign req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  assign hit_wh = (WB_ADR_I == DH_OFS_C);
  assign hit_ms = (WB_ADR_I == MS_OFS_C);
  assign hit_ul = (WB_ADR_I == UNLOCK_OFS_C);
  assign lo_en  = WB_SEL_I[0];
  assign hi_en  = WB_SEL_I[1];
  assign wr_wh  = req & WB_WE_I & hit_wh & UNLOCK_O; // [R8] [R10]
  assign wr_ms  = req & WB_WE_I & hit_ms;
  assign wr_ul  = req & WB_WE_I & hit_ul & lo_en;

  // ==================================================
  // Storage; digits have no reset since their power-up value is undefined
  day_hours_t  wh_r;
  day_hours_t  wh_nxt;
  min_sec_t    ms_r;
  min_sec_t    ms_nxt;
  logic        unlock_nxt;
  logic [31:0] dat_nxt;
  logic        ack_nxt;
  logic        err_nxt;

  always_comb begin
    wh_nxt     = wh_r;
    ms_nxt     = ms_r;
    if (wr_wh && hi_en) begin
      wh_nxt.dow = WB_DAT_I[DOW_LSB_C +: 3]; // [R1]
    end
    if (wr_wh && lo_en) begin
      wh_nxt.hr_tens  = WB_DAT_I[HRT_LSB_C +: 2]; // [R2]
      wh_nxt.hr_units = WB_DAT_I[HRU_LSB_C +: 4]; // [R3]
    end
    if (wr_ms && hi_en) begin
      ms_nxt.min_tens  = WB_DAT_I[MNT_LSB_C +: 3]; // [R4]
      ms_nxt.min_units = WB_DAT_I[MNU_LSB_C +: 4]; // [R5]
    end
    if (wr_ms && lo_en) begin
      ms_nxt.sec_tens  = WB_DAT_I[SCT_LSB_C +: 3]; // [R6]
      ms_nxt.sec_units = WB_DAT_I[SCU_LSB_C +: 4]; // [R7]
    end
  end

  always_ff @(posedge CLK) begin
    wh_r <= wh_nxt;
    ms_r <= ms_nxt;
  end

  // ==================================================
  // Write-unlock bit; resets to zero so weekday/hours starts locked
  always_comb begin
    unlock_nxt = UNLOCK_O;
    if (wr_ul) begin
      unlock_nxt = WB_DAT_I[0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      UNLOCK_O <= UNLOCK_RST_C;
    end else begin
      UNLOCK_O <= unlock_nxt; // [R8]
    end
  end

  // ==================================================
  // Read mux and answer, one cycle after the request
  always_comb begin
    dat_nxt = 32'h0000_0000;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (req) begin
      if (hit_wh) begin
        ack_nxt        = 1'b1;
        dat_nxt[15:0]  = 16'h0000; // [R9]
        dat_nxt[DOW_LSB_C +: 3] = wh_r.dow;
        dat_nxt[HRT_LSB_C +: 2] = wh_r.hr_tens;
        dat_nxt[HRU_LSB_C +: 4] = wh_r.hr_units;
      end else if (hit_ms) begin
        ack_nxt = 1'b1;
        dat_nxt[MNT_LSB_C +: 3] = ms_r.min_tens;
        dat_nxt[MNU_LSB_C +: 4] = ms_r.min_units;
        dat_nxt[SCT_LSB_C +: 3] = ms_r.sec_tens;
        dat_nxt[SCU_LSB_C +: 4] = ms_r.sec_units;
      end else if (hit_ul) begin
        ack_nxt    = 1'b1;
        dat_nxt[0] = UNLOCK_O;
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WB_DAT_O <= 32'h0000_0000;
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
    end else begin
      WB_DAT_O <= dat_nxt;
      WB_ACK_O <= ack_nxt;
      WB_ERR_O <= err_nxt;
    end
  end

  // ==================================================
  // Checks
  property p_locked_hold;
    @(posedge CLK) disable iff (!RSTN)
      (req && WB_WE_I && hit_wh && !UNLOCK_O) |=> $stable(wh_r);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked write changed"); // [R10]

  property p_unlocked_write;
    @(posedge CLK) disable iff (!RSTN)
      (wr_wh && lo_en) |=> (wh_r.hr_units == $past(WB_DAT_I[3:0]));
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("hour write lost"); // [R8]

  property p_dow_field;
    @(posedge CLK) disable iff (!RSTN)
      (req && hit_wh && !WB_WE_I) |=> (WB_DAT_O[10:8] == $past(wh_r.dow));
  endproperty
  a_dow_field: assert property (p_dow_field) else $error("weekday misplaced"); // [R1]

  property p_hrt_field;
    @(posedge CLK) disable iff (!RSTN)
      (req && hit_wh && !WB_WE_I) |=> (WB_DAT_O[5:4] == $past(wh_r.hr_tens));
  endproperty
  a_hrt_field: assert property (p_hrt_field) else $error("hour tens misplaced"); // [R2]

  property p_min_field;
    @(posedge CLK) disable iff (!RSTN)
      (req && hit_ms && !WB_WE_I) |=> (WB_DAT_O[14:8] == $past({ms_r.min_tens, ms_r.min_units}));
  endproperty
  a_min_field: assert property (p_min_field) else $error("minutes misplaced"); // [R4]

  property p_sec_field;
    @(posedge CLK) disable iff (!RSTN)
      (req && hit_ms && !WB_WE_I) |=> (WB_DAT_O[6:0] == $past({ms_r.sec_tens, ms_r.sec_units}));
  endproperty
  a_sec_field: assert property (p_sec_field) else $error("seconds misplaced"); // [R6]

  property p_sec_units;
    @(posedge CLK) disable iff (!RSTN)
      (wr_ms && lo_en) |=> (ms_r.sec_units == $past(WB_DAT_I[3:0]));
  endproperty
  a_sec_units: assert property (p_sec_units) else $error("second units lost"); // [R7]

  property p_min_units;
    @(posedge CLK) disable iff (!RSTN)
      (wr_ms && hi_en) |=> (ms_r.min_units == $past(WB_DAT_I[11:8]));
  endproperty
  a_min_units: assert property (p_min_units) else $error("minute units lost"); // [R5]

  property p_hru_field;
    @(posedge CLK) disable iff (!RSTN)
      (req && hit_wh && !WB_WE_I) |=> (WB_DAT_O[3:0] == $past(wh_r.hr_units));
  endproperty
  a_hru_field: assert property (p_hru_field) else $error("hour units misplaced"); // [R3]

  property p_zero_bits;
    @(posedge CLK) disable iff (!RSTN)
      (req && (hit_wh || hit_ms)) |=>
        ((WB_DAT_O[15:0] & ~($past(hit_wh) ? DH_MASK_C : MS_MASK_C)) == 16'h0000);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit set"); // [R9]

  property p_ack_one;
    @(posedge CLK) disable iff (!RSTN)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");

  property p_err_one;
    @(posedge CLK) disable iff (!RSTN)
      WB_ERR_O |=> !WB_ERR_O;
  endproperty
  a_err_one: assert property (p_err_one) else $error("err held");

  property p_excl;
    @(posedge CLK) disable iff (!RSTN)
      !(WB_ACK_O && WB_ERR_O);
  endproperty
  a_excl: assert property (p_excl) else $error("ack and err together");

  property p_answer_next;
    @(posedge CLK) disable iff (!RSTN)
      req |=> (WB_ACK_O != WB_ERR_O);
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("request not answered");

  property p_quiet;
    @(posedge CLK) disable iff (!RSTN)
      !(WB_CYC_I && WB_STB_I) |=> (!WB_ACK_O && !WB_ERR_O);
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");

  property p_dat_idle;
    @(posedge CLK) disable iff (!RSTN)
      !WB_ACK_O |-> (WB_DAT_O == 32'h0000_0000);
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data without ack");

  property p_upper_zero;
    @(posedge CLK) disable iff (!RSTN)
      WB_DAT_O[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half set"); // [R9]

  property p_unlock_write;
    @(posedge CLK) disable iff (!RSTN)
      wr_ul |=> (UNLOCK_O == $past(WB_DAT_I[0]));
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("unlock write lost"); // [R8]

  property p_unlock_hold;
    @(posedge CLK) disable iff (!RSTN)
      !wr_ul |=> $stable(UNLOCK_O);
  endproperty
  a_unlock_hold: assert property (p_unlock_hold) else $error("unlock changed"); // [R8]

  property p_unlock_read;
    @(posedge CLK) disable iff (!RSTN)
      (req && hit_ul && !WB_WE_I) |=> (WB_DAT_O == {31'h0000_0000, $past(UNLOCK_O)});
  endproperty
  a_unlock_read: assert property (p_unlock_read) else $error("unlock read wrong"); // [R8]

  property p_dow_write;
    @(posedge CLK) disable iff (!RSTN)
      (wr_wh && hi_en) |=> (wh_r.dow == $past(WB_DAT_I[10:8]));
  endproperty
  a_dow_write: assert property (p_dow_write) else $error("weekday write lost"); // [R1]

  property p_hrt_write;
    @(posedge CLK) disable iff (!RSTN)
      (wr_wh && lo_en) |=> (wh_r.hr_tens == $past(WB_DAT_I[5:4]));
  endproperty
  a_hrt_write: assert property (p_hrt_write) else $error("hour tens write lost"); // [R2]

  property p_min_tens_write;
    @(posedge CLK) disable iff (!RSTN)
      (wr_ms && hi_en) |=> (ms_r.min_tens == $past(WB_DAT_I[14:12]));
  endproperty
  a_min_tens_write: assert property (p_min_tens_write) else $error("minute tens lost"); // [R4]

  property p_sec_tens_write;
    @(posedge CLK) disable iff (!RSTN)
      (wr_ms && lo_en) |=> (ms_r.sec_tens == $past(WB_DAT_I[6:4]));
  endproperty
  a_sec_tens_write: assert property (p_sec_tens_write) else $error("second tens lost"); // [R6]

  property p_wh_lane_hold;
    @(posedge CLK) disable iff (!RSTN)
      (wr_wh && !hi_en) |=> $stable(wh_r.dow);
  endproperty
  a_wh_lane_hold: assert property (p_wh_lane_hold) else $error("weekday hit by low lane"); // [R1]

  property p_ms_lane_hold;
    @(posedge CLK) disable iff (!RSTN)
      (wr_ms && !lo_en) |=> $stable({ms_r.sec_tens, ms_r.sec_units});
  endproperty
  a_ms_lane_hold: assert property (p_ms_lane_hold) else $error("seconds hit by high lane"); // [R6]

  // Unmapped access must leave every stored digit and the unlock bit alone
  property p_err_no_write;
    @(posedge CLK) disable iff (!RSTN)
      (req && !hit_wh && !hit_ms && !hit_ul) |=>
        ($stable(wh_r) && $stable(ms_r) && $stable(UNLOCK_O));
  endproperty
  a_err_no_write: assert property (p_err_no_write) else $error("unmapped access wrote");

  c_locked:   cover property (@(posedge CLK) disable iff (!RSTN)
                req && WB_WE_I && hit_wh && !UNLOCK_O);
  c_unlocked: cover property (@(posedge CLK) disable iff (!RSTN) wr_wh);
  c_ms_read:  cover property (@(posedge CLK) disable iff (!RSTN) req && hit_ms && !WB_WE_I);
  c_err:      cover property (@(posedge CLK) disable iff (!RSTN) WB_ERR_O);
  c_lane:     cover property (@(posedge CLK) disable iff (!RSTN) wr_ms && !hi_en);

endmodule : rtc_time_value_registers

/* File: dv/tb_rtc_time_value_registers.sv */
`timescale 1ns/10ps
module tb_rtc_time_value_registers;
  localparam logic [3:0] DH_A = 4'h0;
  localparam logic [3:0] MS_A = 4'h4;
  localparam logic [3:0] UL_A = 4'h8;
  logic        CLK = 1'b0;
  logic        RSTN, cyc, stb, we, ack, err, unl, e;
  logic [3:0]  adr, sel, bsel;
  logic [31:0] wdat, rdo, q;
  int          fails, check_count;
  rtc_time_value_registers dut_u (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdo),
    .WB_ACK_O(ack), .WB_ERR_O(err), .UNLOCK_O(unl));
  always #2 CLK = ~CLK;
  // ==================================================
  // Bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    check_count++;
    if (x !== s) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // Request held until ack or err is sampled high at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= bsel;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = rdo;
    e = err;
    if (n >= 50) chk("bus_answer", 32'h1, 32'h0);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : bus
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask : rdchk
  // ==================================================
  // Scenarios
  task automatic t_reset;
    chk("unlock_out", 32'h0, {31'h0, unl});
    rdchk("unlock_reg", UL_A, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    bus(1'b1, UL_A, 32'h1);
    chk("unlock_out", 32'h1, {31'h0, unl});
    bus(1'b1, DH_A, 32'h0623);
    rdchk("day_hours", DH_A, 32'h0623);
    bus(1'b1, DH_A, 32'h0000);
    rdchk("day_hours", DH_A, 32'h0000);
    bus(1'b1, MS_A, 32'h5959);
    rdchk("min_sec", MS_A, 32'h5959);
    bus(1'b1, MS_A, 32'h0000);
    rdchk("min_sec", MS_A, 32'h0000);
    $display("test fields done");
  endtask : t_fields
  // All ones written: only the digit fields may come back set
  task automatic t_unused;
    bus(1'b1, DH_A, 32'hFFFF_FFFF);
    rdchk("day_hours", DH_A, 32'h073F);
    bus(1'b1, MS_A, 32'hFFFF_FFFF);
    rdchk("min_sec", MS_A, 32'h7F7F);
    $display("test unused done");
  endtask : t_unused
  task automatic t_lock;
    bus(1'b1, DH_A, 32'h0519);
    bus(1'b1, UL_A, 32'h0);
    chk("unlock_out", 32'h0, {31'h0, unl});
    bus(1'b1, DH_A, 32'h0206);
    rdchk("day_hours", DH_A, 32'h0519);
    bus(1'b1, MS_A, 32'h0102);
    rdchk("min_sec", MS_A, 32'h0102);
    bus(1'b1, UL_A, 32'h1);
    bus(1'b1, DH_A, 32'h0206);
    rdchk("day_hours", DH_A, 32'h0206);
    $display("test lock done");
  endtask : t_lock
  task automatic t_unmapped;
    bus(1'b1, 4'hC, 32'hFFFF);
    chk("err_resp", 32'h1, {31'h0, e});
    rdchk("day_hours", DH_A, 32'h0206);
    $display("test unmapped done");
  endtask : t_unmapped
  // One byte lane at a time: the other lane's digits must stay
  task automatic t_lanes;
    bsel = 4'h1;
    bus(1'b1, MS_A, 32'h5948);
    rdchk("min_sec", MS_A, 32'h0148);
    bsel = 4'h2;
    bus(1'b1, MS_A, 32'h3700);
    rdchk("min_sec", MS_A, 32'h3748);
    bus(1'b1, DH_A, 32'h0400);
    rdchk("day_hours", DH_A, 32'h0406);
    bsel = 4'h1;
    bus(1'b1, DH_A, 32'h0513);
    rdchk("day_hours", DH_A, 32'h0413);
    bsel = 4'h3;
    $display("test lanes done");
  endtask : t_lanes
  // ==================================================
  // Closing and main sequence
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    RSTN = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; bsel = 4'h3;
    adr = 4'h0; sel = 4'h0; wdat = 32'h0; fails = 0; check_count = 0;
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    t_reset();
    t_fields();
    t_unused();
    t_lock();
    t_unmapped();
    t_lanes();
    complete_run();
  end
  // Whole run needs well under 400 cycles
  initial begin
    #8000;
    fails++;
    complete_run();
  end
endmodule : tb_rtc_time_value_registers
